// ### core/plc_pkg.sv
// Package with register map, field positions and timing constants of the link control block.
package plc_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] PLC_ADDR_CONTROL = 8'h78;
    localparam logic [7:0] PLC_ADDR_CONFIG  = 8'h79;
    localparam logic [7:0] PLC_CONTROL_RST  = 8'h00;
    localparam logic [7:0] PLC_CONFIG_RST   = 8'h00;

    // Field positions of phy_control.
    localparam int PLC_CN_LAYER  = 7;
    localparam int PLC_CN_TX     = 6;
    localparam int PLC_CN_RX     = 5;
    localparam int PLC_CN_DUPLEX = 4;
    localparam int PLC_CN_LOOP   = 3;
    localparam int PLC_CN_FAULT  = 2;
    localparam int PLC_CN_POLARITY_REVERSED_FLAG = 1;
    localparam int PLC_CN_LINK   = 0;

    // Field positions of phy_config.
    localparam int PLC_CF_SQUELCH = 7;
    localparam int PLC_CF_LINK_INTEGRITY_ENABLE = 6;
    localparam int PLC_CF_JABBER  = 5;
    localparam int PLC_CF_NEG     = 4;
    localparam int PLC_CF_PAUSE   = 2;
    localparam int PLC_CF_AUTO_POLARITY_ENABLE = 1;
    localparam int PLC_CF_MANUAL_POLARITY_INVERT  = 0;
    localparam logic [7:0] PLC_CF_WR_MASK = 8'hF7;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam longint PLC_CLK_HZ        = 20_000_000;
    localparam longint PLC_ATTEMPT_MS    = 250;
    localparam longint PLC_BREAK_MS      = 1500;
    localparam longint PLC_LINK_LOSS_MS  = 150;
    localparam longint PLC_ATTEMPT_CYC   = PLC_ATTEMPT_MS * PLC_CLK_HZ / 1000;
    localparam longint PLC_BREAK_CYC     = PLC_BREAK_MS * PLC_CLK_HZ / 1000;
    localparam longint PLC_LINK_LOSS_CYC = PLC_LINK_LOSS_MS * PLC_CLK_HZ / 1000;
    localparam longint PLC_MAX_FRAME_B   = 1536;
    localparam longint PLC_CYC_PER_BIT   = 2;
    localparam longint PLC_JABBER_CYC    = PLC_MAX_FRAME_B * 8 * PLC_CYC_PER_BIT;
    localparam int     PLC_SQUELCH_CYC   = 4;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic layer;
        logic tx;
        logic rx;
        logic duplex;
        logic loopback;
        logic fault;
        logic polarity_reversed_flag;
        logic link;
    } plc_control_t;

    typedef enum logic [1:0] {
        PLC_NEG_IDLE    = 2'b00,
        PLC_NEG_ATTEMPT = 2'b01,
        PLC_NEG_BREAK   = 2'b10,
        PLC_NEG_DONE    = 2'b11
    } plc_neg_state_t;

endpackage

// ### core/plc_interval_timer.sv
// Down counter that times negotiation attempts and break-link intervals.
module plc_interval_timer
    import plc_pkg::*;
#(
    parameter longint ATTEMPT_CYC = PLC_ATTEMPT_CYC,
    parameter longint BREAK_CYC   = PLC_BREAK_CYC
)
(
    input  wire logic clk_i,
    input  wire logic reset_i,
    input  wire logic start_i,
    input  wire logic sel_break_i,
    input  wire logic stop_i,
    output logic      expire_o
);

    localparam int W = $clog2(BREAK_CYC + 1);

    initial
    begin
        if (ATTEMPT_CYC < 2 || BREAK_CYC < ATTEMPT_CYC)
            $error("Timer counts too small.");
    end

    logic [W-1:0] count;
    logic         running;
    logic [W-1:0] next_count;
    logic         next_running;
    logic         next_expire;

    always_comb
    begin
        next_count   = count;
        next_running = running;
        next_expire  = 1'b0;
        if (stop_i)
        begin
            next_running = 1'b0;
        end
        else if (start_i)
        begin
            next_count   = sel_break_i ? W'(BREAK_CYC - 1) : W'(ATTEMPT_CYC - 1);
            next_running = 1'b1;
        end
        else if (running)
        begin
            next_count = count - W'(1);
            if (count == W'(1))
            begin
                next_running = 1'b0;
                next_expire  = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            count    <= '0;
            running  <= 1'b0;
            expire_o <= 1'b0;
        end
        else
        begin
            count    <= next_count;
            running  <= next_running;
            expire_o <= next_expire;
        end
    end

endmodule

// ### core/plc_rx_qualify.sv
// Receive path qualifier with smart squelch and polarity handling.
module plc_rx_qualify
    import plc_pkg::*;
#(
    parameter int SQUELCH_CYC = PLC_SQUELCH_CYC
)
(
    input  wire logic clk_i,
    input  wire logic reset_i,
    input  wire logic enable_i,
    input  wire logic squelch_en_i,
    input  wire logic auto_pol_i,
    input  wire logic manual_inv_i,
    input  wire logic data_i,
    input  wire logic amp_ok_i,
    input  wire logic timing_ok_i,
    input  wire logic pulse_seen_i,
    input  wire logic pulse_neg_i,
    output logic      data_o,
    output logic      valid_o,
    output logic      pol_rev_o
);

    localparam int W = $clog2(SQUELCH_CYC + 1);

    initial
    begin
        if (SQUELCH_CYC < 1)
            $error("Squelch count too small.");
    end

    logic [W-1:0] qual_cnt;
    logic [W-1:0] next_qual_cnt;
    logic         next_pol_rev;
    logic         next_data;
    logic         next_valid;
    logic         sig_ok;
    logic         invert;

    always_comb
    begin
        sig_ok        = amp_ok_i && timing_ok_i;
        next_qual_cnt = qual_cnt;
        next_pol_rev  = pol_rev_o;
        if (!enable_i || !sig_ok)
            next_qual_cnt = '0;
        else if (qual_cnt != W'(SQUELCH_CYC))
            next_qual_cnt = qual_cnt + W'(1);
        // Polarity follows the sign of the last link pulse seen.
        if (!auto_pol_i)
            next_pol_rev = 1'b0;
        else if (pulse_seen_i)
            next_pol_rev = pulse_neg_i; // [RULE10]
        invert     = auto_pol_i ? pol_rev_o : manual_inv_i; // [RULE11]
        next_data  = data_i ^ invert;
        // Squelch off still needs amplitude.
        next_valid = enable_i && (squelch_en_i ? (qual_cnt == W'(SQUELCH_CYC)) : amp_ok_i); // [RULE9]
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            qual_cnt  <= '0;
            pol_rev_o <= 1'b0;
            data_o    <= 1'b0;
            valid_o   <= 1'b0;
        end
        else
        begin
            qual_cnt  <= next_qual_cnt;
            pol_rev_o <= next_pol_rev;
            data_o    <= next_data;
            valid_o   <= next_valid;
        end
    end

endmodule

// ### core/plc_link_control.sv
// Top of the physical-layer link control: registers, negotiation timing, link and jabber.
// Notes on behaviour
// [RULE1] Attempt 250 ms, then 1.5 s break.
// [RULE2] Break ignores partner, starts nothing.
// [RULE3] Host sync order.
// [RULE4] Host waits per wake flag.
// [RULE5] Loopback isolates line.
// [RULE6] Jabber clears loopback.
// [RULE7] Link loss gates tx, rx.
// [RULE8] No integrity, always runs.
// [RULE9] Squelch needs amplitude, timing.
// [RULE10] Auto polarity corrects, flags.
// [RULE11] Manual bit inverts receive.
// [RULE12] Jabber stops transmit, pulses event.
// [RULE13] Host configures, then enables.
// [RULE14] Host waits startup, then tx, rx.
// [RULE15] Dropping any enable restarts.
// [RULE16] Layer enable sets power.
// [RULE17] Tx off stops pulses.
// [RULE18] Rx off stops reception; loopback still drives mac_rx_valid_o from mac_tx_en_i with rx off.
// [RULE19] Duplex read-only while negotiating.
// [RULE20] Partner fault sets flag.
// [RULE21] Control resets to zero.
// [RULE22] Failure means half duplex.
// [RULE23] Advertise 10M; full if partner can.
// [RULE24] Timers on clock, restart on enable.
module plc_link_control
    import plc_pkg::*;
#(
    parameter longint ATTEMPT_CYC   = PLC_ATTEMPT_CYC,
    parameter longint BREAK_CYC     = PLC_BREAK_CYC,
    parameter longint LINK_LOSS_CYC = PLC_LINK_LOSS_CYC,
    parameter longint JABBER_CYC    = PLC_JABBER_CYC,
    parameter int     SQUELCH_CYC   = PLC_SQUELCH_CYC
)
(
    input  wire logic       clk_i,
    input  wire logic       reset_i,
    input  wire logic [7:0] addr_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    input  wire logic [7:0] wdata_i,
    output logic      [7:0] rdata_o,
    input  wire logic       mac_tx_en_i,
    input  wire logic       mac_tx_data_i,
    input  wire logic       line_rx_data_i,
    input  wire logic       line_amp_ok_i,
    input  wire logic       line_timing_ok_i,
    input  wire logic       line_pulse_i,
    input  wire logic       line_pulse_neg_i,
    input  wire logic       partner_word_i,
    input  wire logic       partner_full_i,
    input  wire logic       partner_fault_i,
    output logic            line_tx_data_o,
    output logic            line_tx_drive_o,
    output logic            link_pulse_gen_o,
    output logic            advertise_full_o,
    output logic            advertise_pause_o,
    output logic            mac_rx_data_o,
    output logic            mac_rx_valid_o,
    output logic            full_duplex_o,
    output logic            layer_power_o,
    output logic            tx_power_o,
    output logic            rx_power_o,
    output logic            wake_event_flag_o,
    output logic            neg_done_o,
    output logic            neg_fail_o,
    output logic            jabber_event_o
);

    localparam int LW = $clog2(LINK_LOSS_CYC + 1);
    localparam int JW = $clog2(JABBER_CYC + 1);

    initial
    begin
        if (LINK_LOSS_CYC < 1 || JABBER_CYC < 1)
            $error("Limits too small.");
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    plc_control_t   ctl;
    plc_control_t   next_ctl;
    logic [7:0]     cfg;
    logic [7:0]     next_cfg;
    plc_neg_state_t neg_state;
    plc_neg_state_t next_neg_state;
    logic [LW-1:0]  link_cnt;
    logic [LW-1:0]  next_link_cnt;
    logic [JW-1:0]  jab_cnt;
    logic [JW-1:0]  next_jab_cnt;
    logic           jabbering;
    logic           next_jabbering;
    logic           neg_active;
    logic           next_neg_active;
    logic           tmr_start;
    logic           tmr_break;
    logic           tmr_expire;
    logic           rx_pol_rev;
    logic           rx_q_data;
    logic           rx_q_valid;
    logic           run;
    logic           tx_ok;
    logic           rx_ok;
    logic           link_cut;
    logic           jab_hit;
    logic           next_done;
    logic           next_fail;
    logic [7:0]     next_rdata;

    // ------------------------------------------------------------
    // Receive qualifier and interval timer
    // ------------------------------------------------------------
    plc_rx_qualify #(
        .SQUELCH_CYC (SQUELCH_CYC)
    ) u_rx (
        .clk_i        (clk_i),
        .reset_i      (reset_i),
        .enable_i     (rx_ok && !ctl.loopback),
        .squelch_en_i (cfg[PLC_CF_SQUELCH]),
        .auto_pol_i   (cfg[PLC_CF_AUTO_POLARITY_ENABLE]),
        .manual_inv_i (cfg[PLC_CF_MANUAL_POLARITY_INVERT]),
        .data_i       (line_rx_data_i),
        .amp_ok_i     (line_amp_ok_i),
        .timing_ok_i  (line_timing_ok_i),
        .pulse_seen_i (line_pulse_i),
        .pulse_neg_i  (line_pulse_neg_i),
        .data_o       (rx_q_data),
        .valid_o      (rx_q_valid),
        .pol_rev_o    (rx_pol_rev)
    );

    plc_interval_timer #(
        .ATTEMPT_CYC (ATTEMPT_CYC),
        .BREAK_CYC   (BREAK_CYC)
    ) u_tmr (
        .clk_i       (clk_i),
        .reset_i     (reset_i),
        .start_i     (tmr_start),
        .sel_break_i (tmr_break),
        .stop_i      (!neg_active),
        .expire_o    (tmr_expire)
    );

    // ------------------------------------------------------------
    // Enables, link integrity and jabber
    // ------------------------------------------------------------
    always_comb
    begin
        run      = ctl.layer; // [RULE16]
        link_cut = cfg[PLC_CF_LINK_INTEGRITY_ENABLE] && !ctl.link; // [RULE7] [RULE8]
        tx_ok    = run && ctl.tx && !link_cut && !jabbering; // [RULE17]
        rx_ok    = run && ctl.rx && !link_cut; // [RULE18]
        // Any enable dropping restarts negotiation.
        next_neg_active = cfg[PLC_CF_NEG] && run && ctl.tx && ctl.rx; // [RULE15] [RULE24]

        next_link_cnt = link_cnt;
        if (!run || line_pulse_i || (line_amp_ok_i && line_timing_ok_i))
            next_link_cnt = '0;
        else if (link_cnt != LW'(LINK_LOSS_CYC))
            next_link_cnt = link_cnt + LW'(1);

        next_jab_cnt   = jab_cnt;
        next_jabbering = jabbering;
        jab_hit        = 1'b0;
        if (!mac_tx_en_i)
        begin
            next_jab_cnt   = '0;
            next_jabbering = 1'b0;
        end
        else if (jab_cnt != JW'(JABBER_CYC))
        begin
            next_jab_cnt = jab_cnt + JW'(1);
        end
        else if (cfg[PLC_CF_JABBER] && !jabbering)
        begin
            next_jabbering = 1'b1; // [RULE12]
            jab_hit        = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Negotiation sequence
    // ------------------------------------------------------------
    always_comb
    begin
        next_neg_state = neg_state;
        tmr_start      = 1'b0;
        tmr_break      = 1'b0;
        next_done      = 1'b0;
        next_fail      = 1'b0;
        if (!neg_active)
        begin
            next_neg_state = PLC_NEG_IDLE;
        end
        else
        begin
            unique case (neg_state)
                PLC_NEG_IDLE:
                begin
                    next_neg_state = PLC_NEG_ATTEMPT;
                    tmr_start      = 1'b1; // [RULE1] [RULE24]
                end
                PLC_NEG_ATTEMPT:
                begin
                    if (partner_word_i)
                    begin
                        next_neg_state = PLC_NEG_DONE;
                        next_done      = 1'b1; // [RULE22]
                    end
                    else if (tmr_expire)
                    begin
                        next_neg_state = PLC_NEG_BREAK;
                        next_fail      = 1'b1; // [RULE22]
                        tmr_start      = 1'b1;
                        tmr_break      = 1'b1; // [RULE1]
                    end
                end
                PLC_NEG_BREAK:
                begin
                    // Partner words are deliberately not looked at here.
                    if (tmr_expire) // [RULE2]
                    begin
                        next_neg_state = PLC_NEG_ATTEMPT;
                        tmr_start      = 1'b1;
                    end
                end
                PLC_NEG_DONE:
                begin
                    next_neg_state = PLC_NEG_DONE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_comb
    begin
        next_ctl = ctl;
        next_cfg = cfg;
        if (wr_i && addr_i == PLC_ADDR_CONTROL)
        begin
            next_ctl.layer    = wdata_i[PLC_CN_LAYER]; // [RULE21]
            next_ctl.tx       = wdata_i[PLC_CN_TX];
            next_ctl.rx       = wdata_i[PLC_CN_RX];
            next_ctl.loopback = wdata_i[PLC_CN_LOOP];
            if (!cfg[PLC_CF_NEG])
                next_ctl.duplex = wdata_i[PLC_CN_DUPLEX]; // [RULE19]
        end
        if (wr_i && addr_i == PLC_ADDR_CONFIG)
            next_cfg = wdata_i & PLC_CF_WR_MASK;
        if (next_done)
        begin
            next_ctl.duplex = partner_full_i; // [RULE19] [RULE23]
            next_ctl.fault  = partner_fault_i; // [RULE20]
        end
        if (next_fail)
            next_ctl.duplex = 1'b0; // [RULE22]
        if (tmr_start && neg_state == PLC_NEG_IDLE)
            next_ctl.fault = 1'b0;
        // Hardware clear wins over a write in the same cycle.
        if (jab_hit)
            next_ctl.loopback = 1'b0; // [RULE6]
        next_ctl.polarity_reversed_flag = rx_pol_rev; // [RULE10]
        next_ctl.link   = run && (link_cnt != LW'(LINK_LOSS_CYC)); // [RULE7]

        next_rdata = rdata_o;
        if (rd_i)
        begin
            unique case (addr_i)
                PLC_ADDR_CONTROL: next_rdata = ctl;
                PLC_ADDR_CONFIG:  next_rdata = cfg;
                default:          next_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            ctl               <= PLC_CONTROL_RST;
            cfg               <= PLC_CONFIG_RST;
            neg_state         <= PLC_NEG_IDLE;
            neg_active        <= 1'b0;
            link_cnt          <= '0;
            jab_cnt           <= '0;
            jabbering         <= 1'b0;
            rdata_o           <= 8'h00;
            line_tx_data_o    <= 1'b0;
            line_tx_drive_o   <= 1'b0;
            link_pulse_gen_o  <= 1'b0;
            advertise_full_o  <= 1'b0;
            advertise_pause_o <= 1'b0;
            mac_rx_data_o     <= 1'b0;
            mac_rx_valid_o    <= 1'b0;
            full_duplex_o     <= 1'b0;
            layer_power_o     <= 1'b0;
            tx_power_o        <= 1'b0;
            rx_power_o        <= 1'b0;
            wake_event_flag_o <= 1'b0;
            neg_done_o        <= 1'b0;
            neg_fail_o        <= 1'b0;
            jabber_event_o    <= 1'b0;
        end
        else
        begin
            ctl               <= next_ctl;
            cfg               <= next_cfg;
            neg_state         <= next_neg_state;
            neg_active        <= next_neg_active;
            link_cnt          <= next_link_cnt;
            jab_cnt           <= next_jab_cnt;
            jabbering         <= next_jabbering;
            rdata_o           <= next_rdata;
            // Loopback quiets the line drivers.
            line_tx_data_o    <= mac_tx_data_i && tx_ok && !ctl.loopback; // [RULE5]
            line_tx_drive_o   <= tx_ok && !ctl.loopback && mac_tx_en_i; // [RULE5]
            link_pulse_gen_o  <= tx_ok && !ctl.loopback; // [RULE17]
            advertise_full_o  <= neg_active; // [RULE23]
            advertise_pause_o <= neg_active && cfg[PLC_CF_PAUSE];
            mac_rx_data_o     <= ctl.loopback ? mac_tx_data_i : rx_q_data; // [RULE5]
            mac_rx_valid_o    <= ctl.loopback ? (run && mac_tx_en_i) : rx_q_valid; // [RULE18]
            full_duplex_o     <= ctl.duplex;
            layer_power_o     <= run; // [RULE16]
            tx_power_o        <= tx_ok; // [RULE17]
            rx_power_o        <= rx_ok; // [RULE18]
            wake_event_flag_o <= run && (line_pulse_i || line_amp_ok_i);
            neg_done_o        <= next_done;
            neg_fail_o        <= next_fail;
            jabber_event_o    <= jab_hit; // [RULE12]
        end
    end

endmodule

// ### bench/plc_link_control_sva.sv
// Port checks for the link control block.
module plc_link_control_sva
    import plc_pkg::*;
#(
    parameter longint ATTEMPT_CYC = PLC_ATTEMPT_CYC,
    parameter longint JABBER_CYC  = PLC_JABBER_CYC
)
(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic mac_tx_en_i,
    input wire logic partner_word_i,
    input wire logic line_tx_drive_o,
    input wire logic link_pulse_gen_o,
    input wire logic mac_rx_valid_o,
    input wire logic full_duplex_o,
    input wire logic layer_power_o,
    input wire logic tx_power_o,
    input wire logic rx_power_o,
    input wire logic wake_event_flag_o,
    input wire logic neg_done_o,
    input wire logic neg_fail_o,
    input wire logic jabber_event_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);
    longint tx_run;
    longint fail_gap;
    // Runs are short, so no wrap.
    always_ff @(posedge clk_i)
    begin
        tx_run   <= (reset_i || !mac_tx_en_i) ? 0 : tx_run + 1;
        fail_gap <= (reset_i || neg_fail_o) ? 0 : fail_gap + 1;
    end
    property p_tx_off; !tx_power_o [*2] |-> !link_pulse_gen_o && !line_tx_drive_o; endproperty
    a_tx_off: assert property (p_tx_off) else $error("tx on");
    property p_rx_off; !rx_power_o [*2] |-> !mac_rx_valid_o; endproperty
    a_rx_off: assert property (p_rx_off) else $error("rx on");
    property p_wake_off; !layer_power_o [*2] |-> !wake_event_flag_o; endproperty
    a_wake_off: assert property (p_wake_off) else $error("wake on");
    property p_fail_half; neg_fail_o |-> ##[0:1] !full_duplex_o; endproperty
    a_fail_half: assert property (p_fail_half) else $error("no fallback");
    property p_fail_gap; neg_fail_o |-> fail_gap >= ATTEMPT_CYC - 1; endproperty
    a_fail_gap: assert property (p_fail_gap) else $error("short attempt");
    property p_brk_quiet; neg_fail_o |=> !neg_done_o [*8]; endproperty
    a_brk_quiet: assert property (p_brk_quiet) else $error("done in break");
    property p_done_cause; neg_done_o |-> $past(partner_word_i); endproperty
    a_done_cause: assert property (p_done_cause) else $error("done uncaused");
    property p_jab_len; jabber_event_o |-> tx_run >= JABBER_CYC - 1; endproperty
    a_jab_len: assert property (p_jab_len) else $error("early jabber");
endmodule

// ### bench/plc_line_partner.sv
// Remote link partner: link pulses, code words and line activity.
module plc_line_partner
(
    input  wire logic clk_i,
    input  wire logic pulse_en_i,
    input  wire logic reverse_i,
    input  wire logic word_i,
    input  wire logic full_i,
    input  wire logic data_en_i,
    input  wire logic data_i,
    output logic      pulse_o = 1'b0,
    output logic      pulse_neg_o = 1'b0,
    output logic      word_o = 1'b0,
    output logic      full_o = 1'b0,
    output logic      fault_o = 1'b0,
    output logic      rx_data_o = 1'b0,
    output logic      amp_ok_o = 1'b0,
    output logic      timing_ok_o = 1'b0
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] phase = 3'h0;
    // Idle lines toggle so stale values never pass.
    always @(negedge clk_i)
    begin
        phase       <= phase + 3'h1;
        pulse_o     <= pulse_en_i && phase == 3'h0;
        pulse_neg_o <= (pulse_en_i && phase == 3'h0) ? reverse_i : ~pulse_neg_o;
        word_o      <= word_i;
        full_o      <= word_i ? full_i : ~full_o;
        fault_o     <= word_i ? 1'b0 : ~fault_o;
        rx_data_o   <= data_en_i ? data_i : ~rx_data_o;
        amp_ok_o    <= data_en_i;
        timing_ok_o <= data_en_i;
    end
endmodule

// ### bench/tb.sv
// Self-checking bench for the link control block.
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int ATT = 20;
    localparam int BRK = 60;
    logic clk_i = 1'b0, reset_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0;
    logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, rdata_o;
    logic mac_tx_en_i = 1'b0, mac_tx_data_i = 1'b0, line_rx_data_i, line_amp_ok_i;
    logic line_timing_ok_i, line_pulse_i, line_pulse_neg_i, partner_word_i, partner_full_i;
    logic partner_fault_i, line_tx_data_o, line_tx_drive_o, link_pulse_gen_o, mac_rx_data_o;
    logic advertise_full_o, advertise_pause_o, mac_rx_valid_o, full_duplex_o, layer_power_o;
    logic tx_power_o, rx_power_o, wake_event_flag_o, neg_done_o, neg_fail_o, jabber_event_o;
    logic p_en = 1'b0, p_rev = 1'b0, p_word = 1'b0, p_full = 1'b0, d_en = 1'b0, d_v = 1'b1;
    logic [31:0] seed = 32'hC61FDFA7;
    int num_errors = 0, check_count = 0, cyc = 0, n, dn;
    plc_link_control #(.ATTEMPT_CYC(ATT), .BREAK_CYC(BRK), .LINK_LOSS_CYC(30),
        .JABBER_CYC(50)) u_dut (.*);
    plc_line_partner u_far (.clk_i, .pulse_en_i(p_en), .reverse_i(p_rev), .word_i(p_word),
        .full_i(p_full), .data_en_i(d_en), .data_i(d_v), .pulse_o(line_pulse_i),
        .pulse_neg_o(line_pulse_neg_i), .word_o(partner_word_i), .full_o(partner_full_i),
        .fault_o(partner_fault_i), .rx_data_o(line_rx_data_i), .amp_ok_o(line_amp_ok_i),
        .timing_ok_o(line_timing_ok_i));
    initial forever #25 clk_i = ~clk_i;
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic results();
        if (num_errors == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        check_count++;
        if (g !== e)
        begin
            num_errors++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_i);
        addr_i = a;
        wdata_i = d;
        wr_i = 1'b1;
        @(negedge clk_i);
        wr_i = 1'b0;
    endtask
    task automatic rc(input string nm, input logic [7:0] a, input logic [7:0] m,
                      input logic [7:0] e);
        @(negedge clk_i);
        addr_i = a;
        rd_i = 1'b1;
        @(negedge clk_i);
        rd_i = 1'b0;
        chk(nm, e, rdata_o & m);
    endtask
    // Waits for an attempt to end; a code word goes out k cycles in.
    task automatic wt(input int k, output int c);
        c = 0;
        do
        begin
            @(negedge clk_i);
            c++;
            p_word = (c == k);
            dn += neg_done_o;
        end
        while (!neg_fail_o && !neg_done_o && c < 300);
        p_word = 1'b0;
    endtask
    always @(posedge clk_i)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            num_errors++;
            results();
        end
    end
    initial
    begin
        repeat (4) @(negedge clk_i);
        reset_i = 1'b0;
        rc("control", 8'h78, 8'hFF, 8'h00);
        rc("config", 8'h79, 8'hFF, 8'h00);
        wr(8'h78, 8'hF7);
        repeat (40) @(negedge clk_i);
        rc("ctl_rw", 8'h78, 8'hFE, 8'hF0);
        chk("power", 8'h07, {5'h0, layer_power_o, tx_power_o, rx_power_o});
        wr(8'h78, 8'hA0);
        repeat (3) @(negedge clk_i);
        chk("tx_off", 8'h00, {6'h0, link_pulse_gen_o, tx_power_o});
        wr(8'h79, 8'h40);
        wr(8'h78, 8'hE0);
        repeat (40) @(negedge clk_i);
        chk("li_gate", 8'h00, {6'h0, tx_power_o, rx_power_o});
        p_en = 1'b1;
        p_rev = 1'b1;
        repeat (30) @(negedge clk_i);
        rc("link", 8'h78, 8'h01, 8'h01);
        wr(8'h79, 8'h02);
        d_en = 1'b1;
        repeat (20) @(negedge clk_i);
        rc("polarity_reversed_flag", 8'h78, 8'h02, 8'h02);
        chk("auto_inv", 8'h00, {7'h0, mac_rx_data_o});
        chk("wake", 8'h01, {7'h0, wake_event_flag_o});
        for (n = 1; n >= 0; n--)
        begin
            wr(8'h79, 8'(n));
            repeat (10) @(negedge clk_i);
            chk("man_inv", 8'(1 - n), {7'h0, mac_rx_data_o});
        end
        d_en = 1'b0;
        wr(8'h79, 8'h80);
        repeat (10) @(negedge clk_i);
        chk("squelch", 8'h00, {7'h0, mac_rx_valid_o});
        d_en = 1'b1;
        repeat (8) @(negedge clk_i);
        chk("qualified", 8'h01, {7'h0, mac_rx_valid_o});
        wr(8'h79, 8'h00);
        wr(8'h78, 8'hE8);
        mac_tx_en_i = 1'b1;
        repeat (16)
        begin
            mac_tx_data_i = seed[0];
            seed = lfsr(seed);
            @(negedge clk_i);
            chk("loop", {7'h0, mac_tx_data_i}, {7'h0, mac_rx_data_o});
            chk("isolate", 8'h00, {6'h0, line_tx_drive_o, link_pulse_gen_o});
        end
        mac_tx_en_i = 1'b0;
        wr(8'h79, 8'h20);
        mac_tx_en_i = 1'b1;
        n = 0;
        repeat (70) @(negedge clk_i) n += jabber_event_o;
        mac_tx_en_i = 1'b0;
        chk("jabber", 8'h01, 8'(n));
        rc("loop_clr", 8'h78, 8'h08, 8'h00);
        wr(8'h78, 8'h00);
        wr(8'h79, 8'h10);
        wr(8'h78, 8'hE0);
        wt(-1, n);
        dn = 0;
        wt(10, n);
        chk("gap", 8'(ATT + BRK), 8'(n));
        chk("brk_word", 8'h00, 8'(dn));
        p_full = seed[0];
        wt(BRK + 5, n);
        chk("done", 8'h01, 8'(dn));
        rc("duplex", 8'h78, 8'h10, {3'h0, p_full, 4'h0});
        wr(8'h78, {3'h7, ~p_full, 4'h0});
        rc("dup_ro", 8'h78, 8'h10, {3'h0, p_full, 4'h0});
        wr(8'h78, 8'hC0);
        wr(8'h78, 8'hE0);
        wt(-1, n);
        chk("restart", 8'h01, 8'(n >= ATT && n <= ATT + 4));
        rc("fallback", 8'h78, 8'h10, 8'h00);
        results();
    end
endmodule
bind plc_link_control plc_link_control_sva #(.ATTEMPT_CYC(ATTEMPT_CYC),
    .JABBER_CYC(JABBER_CYC)) u_sva (.*);
